// ---- rtl/prs_sequencer.sv ----
`timescale 1ns/1ns
`default_nettype none
module prs_sequencer
  import prs_pkg::*;
#(
  parameter logic [PRS_TMR_W-1:0] NV_CYCLES = PRS_TMR_W'(PRS_NV_WRITE_CYCLES) // Write cycle length
) (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Synchronous reset, power-up
  input wire logic protect_pin, // Asynchronous protect pin
  input wire logic frame_start, // Start condition seen, pulse
  input wire logic frame_stop, // Stop condition seen, pulse
  input wire logic addr_valid, // Write address complete, pulse
  input wire logic [15:0] addr, // Write byte address
  input wire logic data_valid, // Write data byte complete, pulse
  input wire logic [7:0] data, // Write data byte
  output logic data_ack, // Acknowledge this data byte
  output logic bus_enable, // Low while writing; no address ack
  output logic array_commit, // Start array program, pulse
  output logic [7:0] protect_config // Register read image
);

  // ==========================================================
  // Protect pin synchroniser
  logic pin_meta_reg; // First stage
  logic pin_sync_reg; // Second stage

  // Two flops before any use of the pin
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= protect_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ==========================================================
  // State declarations
  prs_state_t state_reg; // Sequencer state
  prs_state_t state_next; // Next state
  prs_act_t act_reg; // Action held until stop
  logic [13:0] arr_addr_reg; // Array address of this write
  logic write_enable_latch; // Volatile
  logic reg_write_enable_latch; // Volatile
  logic region_lock_bit0; // Nonvolatile
  logic region_lock_bit1; // Nonvolatile
  logic hw_protect_enable_bit; // Nonvolatile
  logic hw_locked; // Register frozen
  logic addr_locked; // Address lies in locked region
  logic is_reg_addr; // Address targets the register
  logic step3_ok; // Byte fits step three pattern
  logic nv_start; // Launch a write cycle
  logic tmr_busy; // Timer running
  logic tmr_done; // Timer last cycle
  logic [7:0] data_hold_reg; // Register data byte

  // ==========================================================
  // Protection decode
  assign hw_locked = pin_sync_reg & hw_protect_enable_bit;

  // Region compare on the latched address
  always_comb begin
    case ({region_lock_bit1, region_lock_bit0})
      PRS_RL_NONE: addr_locked = 1'b0;
      PRS_RL_QTR: addr_locked = (arr_addr_reg >= PRS_QTR_BASE);
      PRS_RL_HALF: addr_locked = (arr_addr_reg >= PRS_HALF_BASE);
      PRS_RL_ALL: addr_locked = 1'b1;
      default: addr_locked = 1'b1;
    endcase
  end

  // Fixed zeros, program bit set, register latch bit clear
  assign step3_ok = ((data & PRS_ZERO_MASK) == 8'h00) & data[PRS_WEL_POS] & ~data[PRS_RWEL_POS];

  // ==========================================================
  // Transaction state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PRS_ST_IDLE: begin
        if (frame_start) begin
          state_next = PRS_ST_ADDR;
        end
      end
      PRS_ST_ADDR: begin
        if (frame_stop) begin
          state_next = PRS_ST_IDLE;
        end else if (addr_valid) begin
          state_next = is_reg_addr ? PRS_ST_REG : PRS_ST_ARRAY;
        end
      end
      PRS_ST_REG: begin
        if (frame_stop) begin
          state_next = PRS_ST_IDLE;
        end else if (frame_start) begin
          state_next = PRS_ST_ADDR;
        end else if (data_valid) begin
          state_next = PRS_ST_REG_DONE;
        end
      end
      PRS_ST_REG_DONE, PRS_ST_ARRAY: begin
        if (frame_stop) begin
          state_next = nv_start ? PRS_ST_BUSY : PRS_ST_IDLE;
        end else if (frame_start) begin
          state_next = PRS_ST_ADDR;
        end
      end
      PRS_ST_BUSY: begin
        if (tmr_done) begin
          state_next = PRS_ST_IDLE;
        end
      end
      default: state_next = PRS_ST_IDLE;
    endcase
  end

  assign is_reg_addr = (addr == PRS_PROT_ADDR);

  // State register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= PRS_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Array address capture
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      arr_addr_reg <= '0;
    end else if (state_reg == PRS_ST_ADDR && addr_valid) begin
      arr_addr_reg <= addr[13:0];
    end
  end

  // ==========================================================
  // Data byte acknowledge and pending action
  always_comb begin
    data_ack = 1'b0;
    if (data_valid) begin
      case (state_reg)
        PRS_ST_REG: data_ack = 1'b1;
        PRS_ST_ARRAY: data_ack = write_enable_latch & ((act_reg == PRS_ACT_NONE) | addr_locked);
        default: data_ack = 1'b0;
      endcase
    end
  end

  // Decode what the stop will do; a start drops it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      act_reg <= PRS_ACT_NONE;
    end else if (frame_start || frame_stop || state_reg == PRS_ST_BUSY) begin
      act_reg <= PRS_ACT_NONE;
    end else if (data_valid && state_reg == PRS_ST_REG) begin
      // Register latch set: 02h is step three with all bits clear
      if (step3_ok && write_enable_latch && reg_write_enable_latch) begin
        act_reg <= PRS_ACT_NV_REG;
      end else if (data == PRS_CMD_SET_WEL) begin
        act_reg <= PRS_ACT_SET_WEL;
      end else if (data == PRS_CMD_SET_RWEL && write_enable_latch) begin
        act_reg <= PRS_ACT_SET_RWEL;
      end else if (data == PRS_CMD_CLR_WEL && !reg_write_enable_latch) begin
        act_reg <= PRS_ACT_CLR_WEL; // Latches clear one at a time
      end else begin
        act_reg <= PRS_ACT_NONE;
      end
    end else if (data_valid && state_reg == PRS_ST_ARRAY) begin
      // Locked or disabled writes leave nothing to commit
      if (write_enable_latch && !addr_locked) begin
        act_reg <= PRS_ACT_NV_ARRAY;
      end
    end
  end

  // Hardware-protected register writes abort at the stop
  assign nv_start = frame_stop
    & ((act_reg == PRS_ACT_NV_REG & ~hw_locked) | (act_reg == PRS_ACT_NV_ARRAY));

  // ==========================================================
  // Volatile latches, cleared at power-up
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      write_enable_latch <= 1'b0;
    end else if (frame_stop && act_reg == PRS_ACT_SET_WEL) begin
      write_enable_latch <= 1'b1;
    end else if (frame_stop && act_reg == PRS_ACT_CLR_WEL) begin
      write_enable_latch <= 1'b0;
    end
  end

  // Any nonvolatile write clears the register latch
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_write_enable_latch <= 1'b0;
    end else if (nv_start) begin
      reg_write_enable_latch <= 1'b0;
    end else if (frame_stop && act_reg == PRS_ACT_SET_RWEL) begin
      reg_write_enable_latch <= 1'b1;
    end
  end

  // ==========================================================
  // Nonvolatile protection bits; reset stands in for blank cells
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hw_protect_enable_bit <= 1'b0;
      region_lock_bit1 <= 1'b0;
      region_lock_bit0 <= 1'b0;
    end else if (nv_start && act_reg == PRS_ACT_NV_REG) begin
      hw_protect_enable_bit <= data_hold_reg[PRS_HPE_POS];
      region_lock_bit1 <= data_hold_reg[PRS_RL1_POS];
      region_lock_bit0 <= data_hold_reg[PRS_RL0_POS];
    end
  end

  // Step three byte kept until the stop
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      data_hold_reg <= 8'h00;
    end else if (data_valid && state_reg == PRS_ST_REG) begin
      data_hold_reg <= data;
    end
  end

  // ==========================================================
  // Write cycle timer and outputs
  prs_busy_timer #(
    .CYCLES(NV_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(nv_start),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // Interface off for the whole write cycle
  assign bus_enable = (state_reg != PRS_ST_BUSY) & ~tmr_busy;

  // Registered commit pulse and register image
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      array_commit <= 1'b0;
      protect_config <= 8'h00;
    end else begin
      array_commit <= nv_start & (act_reg == PRS_ACT_NV_ARRAY);
      protect_config <= {hw_protect_enable_bit, 2'b00, region_lock_bit1, region_lock_bit0,
                         reg_write_enable_latch, write_enable_latch, 1'b0};
    end
  end

endmodule
`default_nettype wire

// ---- rtl/prs_pkg.sv ----
package prs_pkg;

  // ==========================================================
  // Register map and field layout
  localparam logic [15:0] PRS_PROT_ADDR = 16'hFFFF; // Protection register address
  localparam int PRS_HPE_POS = 7; // Hardware-protect enable bit
  localparam int PRS_RL1_POS = 4; // Region lock bit one
  localparam int PRS_RL0_POS = 3; // Region lock bit zero
  localparam int PRS_RWEL_POS = 2; // Register write enable latch
  localparam int PRS_WEL_POS = 1; // Write enable latch
  localparam logic [7:0] PRS_ZERO_MASK = 8'h61; // Bits that must be zero in step three

  // ==========================================================
  // Command bytes
  localparam logic [7:0] PRS_CMD_SET_WEL = 8'h02; // Step one
  localparam logic [7:0] PRS_CMD_SET_RWEL = 8'h06; // Step two
  localparam logic [7:0] PRS_CMD_CLR_WEL = 8'h00; // Clears write latch

  // ==========================================================
  // Protected region bases (array is 16K bytes)
  localparam logic [13:0] PRS_QTR_BASE = 14'h3000; // Upper quarter
  localparam logic [13:0] PRS_HALF_BASE = 14'h2000; // Upper half
  localparam logic [1:0] PRS_RL_NONE = 2'h0; // No protection
  localparam logic [1:0] PRS_RL_QTR = 2'h1; // Upper quarter locked
  localparam logic [1:0] PRS_RL_HALF = 2'h2; // Upper half locked
  localparam logic [1:0] PRS_RL_ALL = 2'h3; // Whole array locked

  // ==========================================================
  // Timing
  localparam int PRS_CLK_PERIOD_NS = 10; // 100 MHz system clock
  localparam int PRS_NV_WRITE_MS = 10; // Longest nonvolatile write
  localparam int PRS_NV_WRITE_CYCLES = PRS_NV_WRITE_MS * 1000000 / PRS_CLK_PERIOD_NS; // Rounded down
  localparam int PRS_TMR_W = 20; // Timer width

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    PRS_ST_IDLE = 3'b000,
    PRS_ST_ADDR = 3'b001,
    PRS_ST_REG = 3'b010,
    PRS_ST_REG_DONE = 3'b011,
    PRS_ST_ARRAY = 3'b100,
    PRS_ST_BUSY = 3'b101
  } prs_state_t;

  // Action pending until stop
  typedef enum logic [2:0] {
    PRS_ACT_NONE = 3'b000,
    PRS_ACT_SET_WEL = 3'b001,
    PRS_ACT_CLR_WEL = 3'b010,
    PRS_ACT_SET_RWEL = 3'b011,
    PRS_ACT_NV_REG = 3'b100,
    PRS_ACT_NV_ARRAY = 3'b101
  } prs_act_t;

endpackage

// ---- rtl/prs_busy_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module prs_busy_timer
  import prs_pkg::*;
#(
  parameter logic [PRS_TMR_W-1:0] CYCLES = PRS_TMR_W'(PRS_NV_WRITE_CYCLES)
) (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic start, // Begin a write cycle
  output logic busy, // Cycle in progress
  output logic done // Last cycle pulse
);

  // ==========================================================
  // Down counter
  logic [PRS_TMR_W-1:0] count_reg; // Remaining cycles

  // Load on start, run to zero; a start while busy is never issued
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_reg <= '0;
    end else if (start) begin
      count_reg <= CYCLES;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - PRS_TMR_W'(1);
    end
  end

  assign busy = (count_reg != '0);
  assign done = (count_reg == PRS_TMR_W'(1));

endmodule
`default_nettype wire

// ---- test/prs_sequencer_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module prs_sequencer_properties
  import prs_pkg::*;
#(
  parameter logic [PRS_TMR_W-1:0] NV_CYCLES = PRS_TMR_W'(PRS_NV_WRITE_CYCLES) // Write cycle length
) (
  input wire logic clk_sys, // Clock
  input wire logic srst, // Reset
  input wire logic protect_pin, // Protect pin
  input wire logic frame_start, // Start pulse
  input wire logic frame_stop, // Stop pulse
  input wire logic addr_valid, // Address strobe
  input wire logic [15:0] addr, // Address
  input wire logic data_valid, // Data strobe
  input wire logic [7:0] data, // Data byte
  input wire logic data_ack, // Acknowledge
  input wire logic bus_enable, // Interface on
  input wire logic array_commit, // Program pulse
  input wire logic [7:0] protect_config // Register image
);
  // ==========================================================
  // Frame tracking
  logic [15:0] addr_reg; // Address of this frame
  logic [3:0] nbytes_reg; // Bytes seen this frame
  int low_reg; // Cycles with interface off
  logic is_reg; // Frame targets the register
  logic locked; // Frame address is locked
  logic [1:0] rl; // Current lock field
  assign rl = protect_config[PRS_RL1_POS:PRS_RL0_POS];
  assign is_reg = addr_reg == PRS_PROT_ADDR;
  assign locked = rl == PRS_RL_ALL || (rl == PRS_RL_HALF && addr_reg[13:0] >= PRS_HALF_BASE)
    || (rl == PRS_RL_QTR && addr_reg[13:0] >= PRS_QTR_BASE);
  // Address held past its strobe, the bus does not
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      addr_reg <= 16'h0000;
    end else if (addr_valid) begin
      addr_reg <= addr;
    end
  end
  // Byte count saturates so long frames never wrap
  always_ff @(posedge clk_sys) begin
    if (srst || frame_start) begin
      nbytes_reg <= 4'h0;
    end else if (data_valid && nbytes_reg != 4'hF) begin
      nbytes_reg <= nbytes_reg + 4'h1;
    end
  end
  // Length of each busy stretch
  always_ff @(posedge clk_sys) begin
    if (srst || bus_enable) begin
      low_reg <= 0;
    end else begin
      low_reg <= low_reg + 1;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Pin settled through the synchroniser with enable set
  sequence s_pin_held;
    protect_pin [*4] ##0 protect_config[PRS_HPE_POS];
  endsequence
  property p_busy_nack; !bus_enable |-> !data_ack; endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("ack while busy");
  property p_busy_len; $rose(bus_enable) |-> low_reg >= int'(NV_CYCLES) && low_reg <= int'(NV_CYCLES) + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_commit_cause; array_commit |-> $past(frame_stop) ##1 !array_commit; endproperty
  a_commit_cause: assert property (p_commit_cause) else $error("commit without stop");
  property p_commit_wel; array_commit |-> $past(protect_config[PRS_WEL_POS]); endproperty
  a_commit_wel: assert property (p_commit_wel) else $error("commit without latch");
  property p_rwel_clear; $fell(bus_enable) |=> !protect_config[PRS_RWEL_POS]; endproperty
  a_rwel_clear: assert property (p_rwel_clear) else $error("register latch kept");
  property p_one_byte; data_valid && is_reg && nbytes_reg != 4'h0 |-> !data_ack; endproperty
  a_one_byte: assert property (p_one_byte) else $error("extra byte acked");
  property p_first_nack;
    data_valid && !is_reg && nbytes_reg == 4'h0 && !protect_config[PRS_WEL_POS] |-> !data_ack;
  endproperty
  a_first_nack: assert property (p_first_nack) else $error("ack without latch");
  property p_lock_nocommit; frame_stop && !is_reg && nbytes_reg != 4'h0 && locked |=> !array_commit;
  endproperty
  a_lock_nocommit: assert property (p_lock_nocommit) else $error("locked commit");
  property p_freeze; s_pin_held |=> $stable(protect_config[7:3]); endproperty
  a_freeze: assert property (p_freeze) else $error("frozen bits changed");
endmodule
bind prs_sequencer prs_sequencer_properties #(.NV_CYCLES(NV_CYCLES)) u_props (.clk_sys(clk_sys),
  .srst(srst), .protect_pin(protect_pin), .frame_start(frame_start), .frame_stop(frame_stop),
  .addr_valid(addr_valid), .addr(addr), .data_valid(data_valid), .data(data), .data_ack(data_ack),
  .bus_enable(bus_enable), .array_commit(array_commit), .protect_config(protect_config));
`default_nettype wire

// ---- test/prs_master_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module prs_master_model (
  input wire logic clk_sys, // Clock
  input wire logic data_ack, // Device acknowledge
  output logic frame_start, // Start pulse
  output logic frame_stop, // Stop pulse
  output logic addr_valid, // Address strobe
  output logic [15:0] addr, // Address
  output logic data_valid, // Data strobe
  output logic [7:0] data // Data byte
);
  // ==========================================================
  // Idle bus
  initial begin
    {frame_start, frame_stop, addr_valid, data_valid} = 4'h0;
    addr = 16'h0000;
    data = 8'h00;
  end
  // ==========================================================
  // One write frame; released lines show inverted values
  task automatic frame(input logic [15:0] a, input logic [7:0] d, input int n, input bit stp,
    output logic ack0, output logic ackn);
    ack0 = 1'b0;
    ackn = 1'b0;
    @(posedge clk_sys) frame_start <= 1'b1;
    @(posedge clk_sys) begin
      frame_start <= 1'b0;
      addr_valid <= 1'b1;
      addr <= a;
    end
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys) begin
        addr_valid <= 1'b0;
        addr <= ~a;
        data_valid <= 1'b1;
        data <= d;
      end
      @(posedge clk_sys);
      if (i == 0) begin
        ack0 = data_ack;
      end else begin
        ackn = ackn | data_ack;
      end
      data_valid <= 1'b0;
      data <= ~d;
    end
    @(posedge clk_sys) begin
      frame_start <= !stp;
      frame_stop <= stp;
    end
    @(posedge clk_sys) begin
      frame_start <= 1'b0;
      frame_stop <= 1'b0;
    end
    if (!stp) begin
      @(posedge clk_sys) frame_stop <= 1'b1;
      @(posedge clk_sys) frame_stop <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import prs_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [PRS_TMR_W-1:0] NV = 20'h00014; // Short write cycle keeps the run brief
  logic clk_sys = 1'b0; // Clock
  logic srst = 1'b1; // Reset
  logic protect_pin = 1'b0; // Protect pin
  logic frame_start, frame_stop, addr_valid, data_valid, data_ack, bus_enable, array_commit;
  logic [15:0] addr; // Address
  logic [7:0] data, protect_config; // Data and image
  int fails = 0;
  int checks_done = 0;
  int commits = 0; // Program pulses seen
  logic ack0, ackn, cm;
  logic [2:0] r;
  logic [15:0] ta [4] = '{16'h1FFF, 16'h2000, 16'h2FFF, 16'h3000}; // Range edges
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (array_commit === 1'b1) commits++;
  end
  prs_sequencer #(.NV_CYCLES(NV)) uut (.clk_sys(clk_sys), .srst(srst), .protect_pin(protect_pin),
    .frame_start(frame_start), .frame_stop(frame_stop), .addr_valid(addr_valid), .addr(addr),
    .data_valid(data_valid), .data(data), .data_ack(data_ack), .bus_enable(bus_enable),
    .array_commit(array_commit), .protect_config(protect_config));
  prs_master_model u_master (.clk_sys(clk_sys), .data_ack(data_ack), .frame_start(frame_start),
    .frame_stop(frame_stop), .addr_valid(addr_valid), .addr(addr), .data_valid(data_valid), .data(data));
  // ==========================================================
  // Tasks
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n, input bit stp);
    u_master.frame(a, d, n, stp, ack0, ackn);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 100 && bus_enable !== 1'b1; i++) @(posedge clk_sys);
    #1;
  endtask
  // Step two then step three, write latch already set
  task automatic step3(input logic [7:0] d);
    wr(PRS_PROT_ADDR, PRS_CMD_SET_RWEL, 1, 1'b1);
    wr(PRS_PROT_ADDR, d, 1, 1'b1);
    wait_idle();
  endtask
  task automatic end_of_test;
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("config", 8'h00, protect_config)
    wr(16'h0100, 8'h11, 1, 1'b1);
    `CHK("ack", 1'b0, ack0)
    wr(PRS_PROT_ADDR, PRS_CMD_SET_RWEL, 1, 1'b1);
    `CHK("config", 8'h00, protect_config)
    wr(PRS_PROT_ADDR, PRS_CMD_SET_WEL, 1, 1'b1);
    `CHK("config", 8'h02, protect_config)
    `CHK("bus_enable", 1'b1, bus_enable)
    wr(PRS_PROT_ADDR, PRS_CMD_SET_RWEL, 2, 1'b1);
    `CHK("ackn", 1'b0, ackn)
    `CHK("config", 8'h06, protect_config)
    wr(PRS_PROT_ADDR, 8'h9E, 1, 1'b1);
    `CHK("config", 8'h06, protect_config)
    wr(PRS_PROT_ADDR, 8'h9A, 1, 1'b0);
    `CHK("config", 8'h06, protect_config)
    wr(PRS_PROT_ADDR, 8'h0A, 1, 1'b1);
    `CHK("bus_enable", 1'b0, bus_enable)
    `CHK("config", 8'h0A, protect_config)
    wr(16'h0000, 8'h55, 1, 1'b1);
    `CHK("ack", 1'b0, ack0)
    wait_idle();
    for (r = 3'h0; r < 3'h4; r++) begin
      step3({3'h0, r[1:0], 3'h2});
      `CHK("config", {3'h0, r[1:0], 3'h2}, protect_config)
      for (int j = 0; j < 4; j++) begin
        commits = 0;
        wr(ta[j], 8'h5A, 1, 1'b1);
        cm = commits != 0;
        `CHK("ack", 1'b1, ack0)
        `CHK("commit", !(r == 3'h3 || (r == 3'h2 && ta[j] >= 16'h2000) || (r == 3'h1 && ta[j] >= 16'h3000)), cm)
        wait_idle();
      end
    end
    step3(8'h9A);
    `CHK("config", 8'h9A, protect_config)
    wr(PRS_PROT_ADDR, PRS_CMD_CLR_WEL, 1, 1'b1);
    `CHK("config", 8'h98, protect_config)
    wr(16'h3000, 8'h5A, 1, 1'b1);
    `CHK("ack", 1'b0, ack0)
    wr(PRS_PROT_ADDR, PRS_CMD_SET_WEL, 1, 1'b1);
    `CHK("config", 8'h9A, protect_config)
    @(posedge clk_sys) protect_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(PRS_PROT_ADDR, PRS_CMD_SET_RWEL, 1, 1'b1);
    wr(PRS_PROT_ADDR, 8'h02, 1, 1'b1);
    `CHK("bus_enable", 1'b1, bus_enable)
    `CHK("config", 8'h9E, protect_config)
    @(posedge clk_sys) protect_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wr(PRS_PROT_ADDR, 8'h02, 1, 1'b1);
    wait_idle();
    `CHK("config", 8'h02, protect_config)
    end_of_test();
  end
  // Hang guard, far beyond the fewer than a thousand cycles used
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
